// [rtl/lfs_pkg.sv]
// Constants for the LED fault status and group membership register slice.
// Assumes a word-wide register port on one clock, driven by the serial front end.
package lfs_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int N_CH       = 12;
	localparam int ADDR_W     = 7;
	localparam int DATA_W     = 16;
	localparam int SEL_W      = 4;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [6:0] OFS_STAT_GEN       = 7'h05;
	localparam logic [6:0] OFS_TRACE_BREAK    = 7'h07;
	localparam logic [6:0] OFS_FORCED_CLOSED  = 7'h08;
	localparam logic [6:0] OFS_SHORTED_LAMP   = 7'h09;
	localparam logic [6:0] OFS_SET_A          = 7'h0A;
	localparam logic [6:0] OFS_SET_B          = 7'h0B;
	localparam logic [6:0] OFS_SET_C          = 7'h0C;
	localparam logic [6:0] OFS_LAMP_MASK      = 7'h0E;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int STAT_GEN_SHORT_BIT = 3;
	localparam int STAT_GEN_OPEN_BIT  = 4;
	localparam int STAT_GEN_TRACE_BIT = 5;
	localparam int SEL_A_BIT          = 0;
	localparam int SEL_B_BIT          = 1;
	localparam int SEL_C_BIT          = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [11:0] RST_CH_MASK = 12'h000;
	localparam logic [15:0] RST_RDATA   = 16'h0000;

endpackage : lfs_pkg

// [rtl/lfs_flag_bank.sv]
// Twelve sticky fault flags that clear when their register is read.
// Assumes detect pulses and the read strobe are on ref_clk.
`timescale 1ns/1ps
module lfs_flag_bank (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      arst_n,
	// Events
	input  wire logic [lfs_pkg::N_CH-1:0]  detect,
	input  wire logic                      rd_clear,
	// State
	output logic      [lfs_pkg::N_CH-1:0]  flags_q
);
	import lfs_pkg::*;

	logic [N_CH-1:0] flags_d;

	// A fault arriving with the read stays set, so it is never lost
	assign flags_d = (rd_clear ? RST_CH_MASK : flags_q) | detect;

	// Flag storage
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= RST_CH_MASK;
		end else begin
			flags_q <= flags_d;
		end
	end

endmodule : lfs_flag_bank

// [rtl/lfs_group_target.sv]
// Per-channel target decode for one group-addressed broadcast write.
// Assumes the select field and member masks are settled in the write cycle.
`timescale 1ns/1ps
module lfs_group_target (
	// Broadcast request
	input  wire logic                      wr_en,
	input  wire logic [lfs_pkg::SEL_W-1:0] sel,
	// Membership
	input  wire logic [lfs_pkg::N_CH-1:0]  set_a,
	input  wire logic [lfs_pkg::N_CH-1:0]  set_b,
	input  wire logic [lfs_pkg::N_CH-1:0]  set_c,
	input  wire logic [lfs_pkg::N_CH-1:0]  set_d,
	// Channels to load
	output logic      [lfs_pkg::N_CH-1:0]  hit
);
	import lfs_pkg::*;

	wire [N_CH-1:0] hit_a;
	wire [N_CH-1:0] hit_b;
	wire [N_CH-1:0] hit_c;
	wire [N_CH-1:0] hit_d;

	// Each select bit picks one group; groups are ORed so overlap loads once
	assign hit_a = {N_CH{sel[SEL_A_BIT]}} & set_a;
	assign hit_b = {N_CH{sel[SEL_B_BIT]}} & set_b;
	assign hit_c = {N_CH{sel[SEL_C_BIT]}} & set_c;
	assign hit_d = {N_CH{sel[3]}} & set_d;
	// An all-zero select gives no hits, leaving every channel untouched
	assign hit   = {N_CH{wr_en}} & (hit_a | hit_b | hit_c | hit_d);

endmodule : lfs_group_target

// [rtl/lfs_regs.sv]
// LED fault status, bypass override and group membership register slice.
// Assumes a serial front end on ref_clk presents one-cycle register strobes,
// raw fault pins come from outside the clock domain, and dimming logic
// per channel is supplied elsewhere.
//
// Functional notes
// - Twelve open-trace flags set per channel on detection, cleared by reading.
// - Twelve shorted-LED flags set per channel on detection, cleared by reading.
// - Override bit set holds that channel's bypass switch permanently closed.
// - Overridden channel runs at zero duty, ignoring duty and fade settings.
// - Override clear passes normal dimming control to the switch unchanged.
// - Faults detected only while switch open; overridden channel raises none.
// - Twelve-bit group A mask; bit set puts channel in group A.
// - Twelve-bit group B mask; bit set puts channel in group B.
// - Twelve-bit group C mask; bit set puts channel in group C.
// - Members take group phase, fade and their group duty writes.
// - Group A answers phase and fade writes with select 0001.
// - Group B answers phase and fade writes with select 0010.
// - Group C answers phase and fade writes with select 0100.
// - Open-trace summary status bit set when any open-trace flag set.
// - Masked channels' faults never assert the active-low fault output.
// - Select bits pick A, B, C, D; several allowed; zero changes nothing.
`timescale 1ns/1ps
module lfs_regs (
	// Clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       arst_n,
	// Register port from the serial front end
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [lfs_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [lfs_pkg::DATA_W-1:0] reg_wdata,
	output logic      [lfs_pkg::DATA_W-1:0] reg_rdata,
	// Group broadcast writes already decoded by the front end
	input  wire logic                       phase_wr,
	input  wire logic [lfs_pkg::SEL_W-1:0]  phase_target_sets,
	input  wire logic                       fade_wr,
	input  wire logic [lfs_pkg::SEL_W-1:0]  fade_target_sets,
	input  wire logic                       set_a_duty_wr,
	input  wire logic                       set_b_duty_wr,
	input  wire logic                       set_c_duty_wr,
	input  wire logic [lfs_pkg::N_CH-1:0]   set_d_members,
	// Fault detector pins (asynchronous)
	input  wire logic [lfs_pkg::N_CH-1:0]   open_trace_raw,
	input  wire logic [lfs_pkg::N_CH-1:0]   shorted_lamp_raw,
	input  wire logic [lfs_pkg::N_CH-1:0]   open_lamp_flags,
	// Dimming control from the per-channel engines
	input  wire logic [lfs_pkg::N_CH-1:0]   dim_switch_open,
	// Switch drive and channel loads
	output logic      [lfs_pkg::N_CH-1:0]   switch_open,
	output logic      [lfs_pkg::N_CH-1:0]   duty_zero,
	output logic      [lfs_pkg::N_CH-1:0]   phase_load,
	output logic      [lfs_pkg::N_CH-1:0]   fade_load,
	output logic      [lfs_pkg::N_CH-1:0]   duty_load,
	// Status
	output logic                            trace_summary,
	output logic                            fault_out_n
);
	import lfs_pkg::*;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [N_CH-1:0]   force_bypass_closed_q;
	logic [N_CH-1:0]   set_a_members_q;
	logic [N_CH-1:0]   set_b_members_q;
	logic [N_CH-1:0]   set_c_members_q;
	logic [N_CH-1:0]   lamp_fault_mask_q;
	logic [N_CH-1:0]   trace_flags_q;
	logic [N_CH-1:0]   shorted_lamp_flags;
	logic [N_CH-1:0]   trace_s1_q;
	logic [N_CH-1:0]   trace_s2_q;
	logic [N_CH-1:0]   short_s1_q;
	logic [N_CH-1:0]   short_s2_q;
	logic [N_CH-1:0]   open_s1_q;
	logic [N_CH-1:0]   open_s2_q;
	logic [N_CH-1:0]   sw_open_q;
	logic [DATA_W-1:0] rdata_d;
	logic [N_CH-1:0]   phase_hit;
	logic [N_CH-1:0]   fade_hit;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire wr_override = reg_wr && (reg_addr == OFS_FORCED_CLOSED);
	wire wr_set_a    = reg_wr && (reg_addr == OFS_SET_A);
	wire wr_set_b    = reg_wr && (reg_addr == OFS_SET_B);
	wire wr_set_c    = reg_wr && (reg_addr == OFS_SET_C);
	wire wr_mask     = reg_wr && (reg_addr == OFS_LAMP_MASK);
	wire rd_trace    = reg_rd && (reg_addr == OFS_TRACE_BREAK);
	wire rd_short    = reg_rd && (reg_addr == OFS_SHORTED_LAMP);

	// ------------------------------------------------------------------
	// Fault pin synchronisers
	// ------------------------------------------------------------------
	// Two stages per pin; only the second stage feeds logic
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			trace_s1_q <= RST_CH_MASK;
			trace_s2_q <= RST_CH_MASK;
			short_s1_q <= RST_CH_MASK;
			short_s2_q <= RST_CH_MASK;
			open_s1_q  <= RST_CH_MASK;
			open_s2_q  <= RST_CH_MASK;
		end else begin
			trace_s1_q <= open_trace_raw;
			trace_s2_q <= trace_s1_q;
			short_s1_q <= shorted_lamp_raw;
			short_s2_q <= short_s1_q;
			open_s1_q  <= open_lamp_flags;
			open_s2_q  <= open_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Switch control
	// ------------------------------------------------------------------
	// Override closes the switch; otherwise dimming passes straight through
	wire [N_CH-1:0] sw_open_d = dim_switch_open & ~force_bypass_closed_q;

	// Detection is qualified by the registered open state of the switch,
	// so an overridden channel can never raise a new fault
	wire [N_CH-1:0] det_trace = trace_s2_q & sw_open_q;
	wire [N_CH-1:0] det_short = short_s2_q & sw_open_q;
	wire [N_CH-1:0] det_open  = open_s2_q & sw_open_q;

	// ------------------------------------------------------------------
	// Sticky status flags
	// ------------------------------------------------------------------
	lfs_flag_bank u_trace_flags (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.detect   (det_trace),
		.rd_clear (rd_trace),
		.flags_q  (trace_flags_q)
	);

	lfs_flag_bank u_short_flags (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.detect   (det_short),
		.rd_clear (rd_short),
		.flags_q  (shorted_lamp_flags)
	);

	// ------------------------------------------------------------------
	// Group broadcast targets
	// ------------------------------------------------------------------
	lfs_group_target u_phase_tgt (
		.wr_en (phase_wr),
		.sel   (phase_target_sets),
		.set_a (set_a_members_q),
		.set_b (set_b_members_q),
		.set_c (set_c_members_q),
		.set_d (set_d_members),
		.hit   (phase_hit)
	);

	lfs_group_target u_fade_tgt (
		.wr_en (fade_wr),
		.sel   (fade_target_sets),
		.set_a (set_a_members_q),
		.set_b (set_b_members_q),
		.set_c (set_c_members_q),
		.set_d (set_d_members),
		.hit   (fade_hit)
	);

	// Each duty register loads only its own group's members
	wire [N_CH-1:0] duty_hit = ({N_CH{set_a_duty_wr}} & set_a_members_q)
	                         | ({N_CH{set_b_duty_wr}} & set_b_members_q)
	                         | ({N_CH{set_c_duty_wr}} & set_c_members_q);

	// Faults from masked channels are kept off the fault pin
	wire [N_CH-1:0] pin_faults = (trace_flags_q | shorted_lamp_flags | det_open)
	                           & ~lamp_fault_mask_q;

	// ------------------------------------------------------------------
	// Read data mux
	// ------------------------------------------------------------------
	// Unmapped offsets read zero; the front end owns the rest of the map
	always_comb begin
		rdata_d = RST_RDATA;
		case (reg_addr)
			OFS_STAT_GEN: begin
				rdata_d[STAT_GEN_TRACE_BIT] = |trace_flags_q;
				rdata_d[STAT_GEN_SHORT_BIT] = |shorted_lamp_flags;
			end
			OFS_TRACE_BREAK:   rdata_d[N_CH-1:0] = trace_flags_q;
			OFS_FORCED_CLOSED: rdata_d[N_CH-1:0] = force_bypass_closed_q;
			OFS_SHORTED_LAMP:  rdata_d[N_CH-1:0] = shorted_lamp_flags;
			OFS_SET_A:         rdata_d[N_CH-1:0] = set_a_members_q;
			OFS_SET_B:         rdata_d[N_CH-1:0] = set_b_members_q;
			OFS_SET_C:         rdata_d[N_CH-1:0] = set_c_members_q;
			OFS_LAMP_MASK:     rdata_d[N_CH-1:0] = lamp_fault_mask_q;
			default:           rdata_d = RST_RDATA;
		endcase
	end

	// ------------------------------------------------------------------
	// Writable registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			force_bypass_closed_q <= RST_CH_MASK;
			set_a_members_q       <= RST_CH_MASK;
			set_b_members_q       <= RST_CH_MASK;
			set_c_members_q       <= RST_CH_MASK;
			lamp_fault_mask_q     <= RST_CH_MASK;
		end else begin
			if (wr_override) force_bypass_closed_q <= reg_wdata[N_CH-1:0];
			if (wr_set_a)    set_a_members_q       <= reg_wdata[N_CH-1:0];
			if (wr_set_b)    set_b_members_q       <= reg_wdata[N_CH-1:0];
			if (wr_set_c)    set_c_members_q       <= reg_wdata[N_CH-1:0];
			if (wr_mask)     lamp_fault_mask_q     <= reg_wdata[N_CH-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	// All outputs registered; loads lag the broadcast strobe by one cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_open_q     <= RST_CH_MASK;
			duty_zero     <= RST_CH_MASK;
			phase_load    <= RST_CH_MASK;
			fade_load     <= RST_CH_MASK;
			duty_load     <= RST_CH_MASK;
			trace_summary <= 1'b0;
			fault_out_n   <= 1'b1;
			reg_rdata     <= RST_RDATA;
		end else begin
			sw_open_q     <= sw_open_d;
			duty_zero     <= force_bypass_closed_q;
			phase_load    <= phase_hit;
			fade_load     <= fade_hit & ~force_bypass_closed_q;
			duty_load     <= duty_hit & ~force_bypass_closed_q;
			trace_summary <= |trace_flags_q;
			fault_out_n   <= ~(|pin_faults);
			reg_rdata     <= rdata_d;
		end
	end

	assign switch_open = sw_open_q;

endmodule : lfs_regs

// [tb/lfs_regs_chk.sv]
// Checker: timing relations on the register slice ports.
// Assumes it is bound to lfs_regs from the bench top file.
`timescale 1ns/1ps
module lfs_regs_chk (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// Broadcast strobes
	input wire logic        phase_wr,
	input wire logic [3:0]  phase_target_sets,
	input wire logic        fade_wr,
	input wire logic [3:0]  fade_target_sets,
	input wire logic        set_a_duty_wr,
	input wire logic        set_b_duty_wr,
	input wire logic        set_c_duty_wr,
	// Switch and loads
	input wire logic [11:0] dim_switch_open,
	input wire logic [11:0] switch_open,
	input wire logic [11:0] duty_zero,
	input wire logic [11:0] phase_load,
	input wire logic [11:0] fade_load,
	input wire logic [11:0] duty_load
);
	// --------
	// Properties
	// --------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	a_override_closed: assert property ((switch_open & duty_zero) == 12'h000)
		else $error("overridden switch open");
	a_switch_follows: assert property (switch_open == ($past(dim_switch_open) & ~duty_zero))
		else $error("switch not following dimming");
	a_zero_duty: assert property ((duty_zero & (fade_load | duty_load)) == 12'h000)
		else $error("overridden channel loaded");
	a_phase_none: assert property (phase_wr && phase_target_sets == 4'h0
		|=> phase_load == 12'h000)
		else $error("empty select loaded phase");
	a_fade_none: assert property (fade_wr && fade_target_sets == 4'h0
		|=> fade_load == 12'h000)
		else $error("empty select loaded fade");
	a_phase_cause: assert property (|phase_load |-> $past(phase_wr))
		else $error("phase load without strobe");
	a_fade_cause: assert property (|fade_load |-> $past(fade_wr))
		else $error("fade load without strobe");
	a_duty_cause: assert property (|duty_load |->
		$past(set_a_duty_wr | set_b_duty_wr | set_c_duty_wr))
		else $error("duty load without strobe");
	// Main scenarios reached
	c_phase: cover property (|phase_load);
	c_duty: cover property (|duty_load);
	c_override: cover property (|duty_zero);
endmodule : lfs_regs_chk

// [tb/lfs_host_model.sv]
// Host controller model: one register transfer at a time on the slice port.
// Assumes the slice samples strobes on the rising edge of ref_clk.
`timescale 1ns/1ps
module lfs_host_model (
	// Clock
	input wire logic   ref_clk,
	// Register port
	output logic       reg_wr = 1'b0,
	output logic       reg_rd = 1'b0,
	output logic [6:0] reg_addr = 7'h00,
	output logic [15:0] reg_wdata = 16'h0000,
	// High in the cycle the read return is due
	output logic       rd_done = 1'b0
);
	// Write strobe for one cycle; data flips afterwards so nothing relies on a stale bus
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// Read strobe; the address holds so the return stays valid for the watcher
	task automatic rd(input logic [6:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		rd_done <= 1'b1;
		@(posedge ref_clk);
		rd_done <= 1'b0;
	endtask : rd
endmodule : lfs_host_model

// [tb/lfs_regs_tb_top.sv]
// Bench top: host model, slice, queued expectations and a result watcher.
// Assumes the slice and host model tasks follow the one-cycle strobe handshake.
`timescale 1ns/1ps
module lfs_regs_tb_top;
	import lfs_pkg::*;
	logic ref_clk = 1'b0, arst_n = 1'b0, reg_wr, reg_rd, rd_done, trace_summary, fault_out_n;
	logic phase_wr = 1'b0, fade_wr = 1'b0, set_a_duty_wr = 1'b0;
	logic set_b_duty_wr = 1'b0, set_c_duty_wr = 1'b0;
	logic [3:0] phase_target_sets = 4'h0, fade_target_sets = 4'h0;
	logic [6:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, seed = 16'h0003;
	logic [11:0] set_d_members = 12'h000, open_trace_raw = 12'h000, shorted_lamp_raw = 12'h000;
	logic [11:0] open_lamp_flags = 12'h000, dim_switch_open = 12'h000, ov, u, m[3];
	logic [11:0] switch_open, duty_zero, phase_load, fade_load, duty_load;
	logic [15:0] q_rd[$];
	logic [35:0] q_ld[$];
	logic [3:0] sels[8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h7, 4'hF, 4'h0};
	int err_count = 0, total_checks = 0;
	always #4 ref_clk = ~ref_clk;
	lfs_host_model lfs_host_model_inst (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .rd_done);
	lfs_regs lfs_regs_inst (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.phase_wr, .phase_target_sets, .fade_wr, .fade_target_sets, .set_a_duty_wr,
		.set_b_duty_wr, .set_c_duty_wr, .set_d_members, .open_trace_raw, .shorted_lamp_raw,
		.open_lamp_flags, .dim_switch_open, .switch_open, .duty_zero, .phase_load, .fade_load,
		.duty_load, .trace_summary, .fault_out_n);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	task automatic rd_exp(input logic [6:0] a, input logic [11:0] e);
		q_rd.push_back({4'h0, e});
		lfs_host_model_inst.rd(a);
	endtask : rd_exp
	// One broadcast strobe: k 0 phase, 1 fade, 2 to 4 duty of sets A to C; select flips after
	task automatic bcast(input int k, input logic [3:0] s, input logic [35:0] e);
		if (e != 36'h0) q_ld.push_back(e);
		@(posedge ref_clk);
		{phase_wr, fade_wr, set_a_duty_wr, set_b_duty_wr, set_c_duty_wr} <= 5'h10 >> k;
		phase_target_sets <= s;
		fade_target_sets <= s;
		@(posedge ref_clk);
		{phase_wr, fade_wr, set_a_duty_wr, set_b_duty_wr, set_c_duty_wr} <= 5'h00;
		phase_target_sets <= ~s;
		fade_target_sets <= ~s;
	endtask : bcast
	// Result watcher: each read return or load pulse consumes the oldest note
	always @(posedge ref_clk) begin
		if (rd_done) check(36'(reg_rdata), q_rd.size() ? 36'(q_rd.pop_front()) : 'x, "read");
		if (|{phase_load, fade_load, duty_load})
			check({phase_load, fade_load, duty_load}, q_ld.size() ? q_ld.pop_front() : 'x, "load");
	end
	// Hang guard, far beyond the under two hundred cycles the tests need
	initial begin
		#100000;
		err_count++;
		$display("watchdog expired");
		final_report();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		lfs_host_model_inst.wr(OFS_TRACE_BREAK, 16'hFFFF);
		for (int a = 7; a < 13; a++) rd_exp(7'(a), RST_CH_MASK);
		rd_exp(7'h7F, 12'h000);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			m[i] = seed[11:0];
			lfs_host_model_inst.wr(OFS_SET_A + 7'(i), seed);
		end
		for (int i = 0; i < 3; i++) rd_exp(OFS_SET_A + 7'(i), m[i]);
		seed = lfsr(seed);
		ov = seed[11:0];
		set_d_members <= seed[15:4];
		dim_switch_open <= seed[13:2];
		lfs_host_model_inst.wr(OFS_FORCED_CLOSED, seed);
		rd_exp(OFS_FORCED_CLOSED, ov);
		check(36'(switch_open), 36'(dim_switch_open & ~ov), "switch");
		check(36'(duty_zero), 36'(ov), "zero duty");
		foreach (sels[i]) begin
			u = (sels[i][0] ? m[0] : 12'h000) | (sels[i][1] ? m[1] : 12'h000);
			u = u | (sels[i][2] ? m[2] : 12'h000) | (sels[i][3] ? set_d_members : 12'h000);
			bcast(0, sels[i], {u, 24'h0});
			bcast(1, sels[i], {12'h0, u & ~ov, 12'h0});
		end
		for (int k = 2; k < 5; k++) bcast(k, 4'h0, {24'h0, m[k-2] & ~ov});
		$display("test groups done");
		lfs_host_model_inst.wr(OFS_FORCED_CLOSED, 16'h0001);
		lfs_host_model_inst.wr(OFS_LAMP_MASK, 16'h0004);
		dim_switch_open <= 12'hFFF;
		open_trace_raw <= 12'h002;
		shorted_lamp_raw <= 12'h001;
		repeat (6) @(posedge ref_clk);
		check(36'({trace_summary, fault_out_n}), 36'h2, "trace fault");
		open_trace_raw <= 12'h000;
		shorted_lamp_raw <= 12'h000;
		repeat (4) @(posedge ref_clk);
		rd_exp(OFS_STAT_GEN, 12'h020);
		rd_exp(OFS_TRACE_BREAK, 12'h002);
		rd_exp(OFS_TRACE_BREAK, 12'h000);
		rd_exp(OFS_SHORTED_LAMP, 12'h000);
		shorted_lamp_raw <= 12'h004;
		repeat (6) @(posedge ref_clk);
		check(36'(fault_out_n), 36'h1, "masked fault");
		shorted_lamp_raw <= 12'h00C;
		repeat (6) @(posedge ref_clk);
		check(36'(fault_out_n), 36'h0, "short fault");
		rd_exp(OFS_STAT_GEN, 12'h008);
		rd_exp(OFS_SHORTED_LAMP, 12'h00C);
		rd_exp(OFS_SHORTED_LAMP, 12'h00C);
		shorted_lamp_raw <= 12'h000;
		repeat (4) @(posedge ref_clk);
		rd_exp(OFS_SHORTED_LAMP, 12'h00C);
		rd_exp(OFS_SHORTED_LAMP, 12'h000);
		// Open-LED levels: channel 0 overridden and channel 2 masked stay silent
		open_lamp_flags <= 12'h005;
		repeat (6) @(posedge ref_clk);
		check(36'(fault_out_n), 36'h1, "open masked");
		open_lamp_flags <= 12'h015;
		repeat (6) @(posedge ref_clk);
		check(36'(fault_out_n), 36'h0, "open fault");
		open_lamp_flags <= 12'h000;
		$display("test faults done");
		repeat (3) @(posedge ref_clk);
		// A note still queued means an expected result never appeared
		check(36'(q_ld.size() + q_rd.size()), 36'h0, "notes left");
		final_report();
	end
endmodule : lfs_regs_tb_top
bind lfs_regs lfs_regs_chk lfs_regs_chk_inst (.ref_clk, .arst_n, .phase_wr, .phase_target_sets,
	.fade_wr, .fade_target_sets, .set_a_duty_wr, .set_b_duty_wr, .set_c_duty_wr,
	.dim_switch_open, .switch_open, .duty_zero, .phase_load, .fade_load, .duty_load);
